//--- rtl/rrc_params.svh
// Purpose: named offsets, bit positions, reset values and codes of the capability shadow
// Assumes: 8-bit register port, two serial ports
// Notes:   definitions only
`ifndef RRC_PARAMS_SVH
`define RRC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RRC_ADDR_PORT_SEL     8'h1E
`define RRC_ADDR_CAP1         8'h20
`define RRC_ADDR_CAP2         8'h21

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RRC_BIT_FREEZE        7
`define RRC_BIT_MODE0         6
`define RRC_BIT_FREQ          5
`define RRC_BIT_EQ            4
`define RRC_BIT_DUAL          3
`define RRC_BIT_CHAN          2
`define RRC_BIT_P1_ADDR_EN    2
`define RRC_BIT_P1_SEL        1
`define RRC_BIT_P0_SEL        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RRC_CAP1_RST          8'h00
`define RRC_CAP2_RST          2'h0
`define RRC_PSEL_RST          3'h4
`define RRC_RDATA_RST         8'h00
`define RRC_COUNT_RST         3'h0

// ----------------------------------------------------------------
// fast control-channel mode codes and gpio counts
// ----------------------------------------------------------------
`define RRC_MODE_NORMAL       3'h0
`define RRC_MODE_HS1          3'h1
`define RRC_MODE_HS2          3'h2
`define RRC_MODE_HS4          3'h3
`define RRC_GPIO_NONE         3'h0
`define RRC_GPIO_ONE          3'h1
`define RRC_GPIO_TWO          3'h2
`define RRC_GPIO_FOUR         3'h4

`endif

//--- rtl/rrc_pkg.sv
// Purpose: types of the capability shadow
// Assumes: nothing
// Notes:   used with package scope, never imported
package rrc_pkg;

    typedef enum logic [2:0] {
        RRC_FCC_NORMAL,
        RRC_FCC_HS1,
        RRC_FCC_HS2,
        RRC_FCC_HS4,
        RRC_FCC_OTHER
    } rrc_fcc_mode_e;

endpackage : rrc_pkg

//--- rtl/rrc_port_shadow.sv
// Purpose: capability copy of one serial port
// Assumes: software write has priority over an auto-load in the same cycle
// Notes:   auto-load is armed by a rising receive lock
`include "rrc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rrc_port_shadow (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       wr_cap1,
    input  wire logic       wr_cap2,
    input  wire logic [7:0] wdata,
    input  wire logic       rx_lock,
    input  wire logic       bcc_valid,
    input  wire logic [6:0] bcc_cap1,
    input  wire logic [1:0] bcc_mode_hi,
    output logic      [7:0] cap1_reg,
    output logic      [1:0] cap2_reg
);

    // ----------------------------------------------------------------
    // arm and load
    // ----------------------------------------------------------------
    logic lock_d_reg;
    logic arm_reg;
    logic arm_next;
    wire  frozen    = cap1_reg[`RRC_BIT_FREEZE];
    wire  lock_rise = rx_lock & ~lock_d_reg;
    wire  load      = arm_reg & bcc_valid & rx_lock & ~frozen;
    // frozen or a clearing of freeze drops the arm until the next lock rise
    assign arm_next = frozen ? 1'b0 : (lock_rise | (arm_reg & ~load));

    wire [7:0] cap1_next = wr_cap1 ? wdata :
                           load    ? {cap1_reg[`RRC_BIT_FREEZE], bcc_cap1} :
                                     cap1_reg;
    wire [1:0] cap2_next = wr_cap2 ? wdata[1:0] :
                           load    ? bcc_mode_hi :
                                     cap2_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lock_d_reg <= 1'b0;
            arm_reg    <= 1'b0;
            cap1_reg   <= `RRC_CAP1_RST;
            cap2_reg   <= `RRC_CAP2_RST;
        end else begin
            lock_d_reg <= rx_lock;
            arm_reg    <= arm_next;
            cap1_reg   <= cap1_next;
            cap2_reg   <= cap2_next;
        end
    end

endmodule : rrc_port_shadow

`default_nettype wire

//--- rtl/rrc_top.sv
// Purpose: remote receiver capability shadow for two serial ports
// Assumes: register port strobes are one-cycle pulses synchronous to sys_clk
// Notes:   read data appears one cycle after the read strobe
//
// Function
// - freeze bit set stops control-channel auto-reload of every capability field
// - while frozen, capability values stay as software wrote them and are used
// - first register bit 6 is mode code LSB; upper two bits in second register
// - after receive lock, capability fields load from channel data unless frozen
// - bit 5 set requests the frequency training pattern on the link
// - bit 4 set requests the equalization training pattern on the link
// - bit 3 tells dual-link capability; link configuration respects it
// - for dual-link receivers bit 2 selects channel: 0 primary, 1 secondary
// - view select steers capability reads and writes to the second port copy while the secondary address is disabled
// - mode code 000 normal frame, 001 one, 010 two, 011 four fast gpios
// - with secondary address disabled, view select routes primary-address access to second port and shared registers
`include "rrc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rrc_top (
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    input  wire logic [7:0]      reg_addr,
    input  wire logic            reg_sec_addr,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire logic [7:0]      reg_wdata,
    output logic      [7:0]      reg_rdata,
    input  wire logic [1:0]      rx_lock,
    input  wire logic [1:0]      bcc_valid,
    input  wire logic [1:0][6:0] bcc_cap1,
    input  wire logic [1:0][1:0] bcc_mode_hi,
    input  wire logic            dual_link_request,
    output logic      [1:0]      send_frequency_training,
    output logic      [1:0]      send_equalization_training,
    output logic      [1:0]      dual_link_capable,
    output logic      [1:0]      channel_index_flag,
    output logic      [1:0][2:0] fast_ctrl_gpio_count,
    output logic      [1:0]      fast_ctrl_mode_reserved,
    output logic                 dual_link_active,
    output logic                 second_port_address_enable,
    output logic                 second_port_view_select
);

    // ----------------------------------------------------------------
    // port select register
    // ----------------------------------------------------------------
    logic [2:0] psel_reg;
    wire        addr_psel = (reg_addr == `RRC_ADDR_PORT_SEL);
    wire        addr_cap1 = (reg_addr == `RRC_ADDR_CAP1);
    wire        addr_cap2 = (reg_addr == `RRC_ADDR_CAP2);
    wire        p1_addr_en = psel_reg[`RRC_BIT_P1_ADDR_EN];
    wire        p1_view    = psel_reg[`RRC_BIT_P1_SEL];

    // secondary address reaches port 1 only when enabled; view select is
    // ignored while the secondary address is enabled
    wire        access_ok  = ~reg_sec_addr | p1_addr_en;
    wire        tgt_p1     = reg_sec_addr ? 1'b1 : (~p1_addr_en & p1_view);
    wire        wr_ok      = reg_wr & access_ok;
    wire        rd_ok      = reg_rd & access_ok;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            psel_reg <= `RRC_PSEL_RST;
        end else if (wr_ok && addr_psel) begin
            psel_reg <= reg_wdata[2:0];
        end
    end

    assign second_port_address_enable = p1_addr_en;
    assign second_port_view_select    = p1_view;

    // ----------------------------------------------------------------
    // per-port shadows and link outputs
    // ----------------------------------------------------------------
    logic [1:0][7:0] cap1_q;
    logic [1:0][1:0] cap2_q;
    logic [1:0]      wr_cap1;
    logic [1:0]      wr_cap2;
    logic [1:0][2:0] mode_code;
    logic [1:0][2:0] gpio_cnt_reg;
    logic [1:0]      mode_rsv_reg;

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_port
            wire                 sel_p = (tgt_p1 == (p == 1));
            rrc_pkg::rrc_fcc_mode_e fcc_mode;
            logic [2:0]          gpio_cnt_next;

            assign wr_cap1[p] = wr_ok & addr_cap1 & sel_p;
            assign wr_cap2[p] = wr_ok & addr_cap2 & sel_p;

            rrc_port_shadow u_shadow (
                .sys_clk     (sys_clk),
                .resetn      (resetn),
                .wr_cap1     (wr_cap1[p]),
                .wr_cap2     (wr_cap2[p]),
                .wdata       (reg_wdata),
                .rx_lock     (rx_lock[p]),
                .bcc_valid   (bcc_valid[p]),
                .bcc_cap1    (bcc_cap1[p]),
                .bcc_mode_hi (bcc_mode_hi[p]),
                .cap1_reg    (cap1_q[p]),
                .cap2_reg    (cap2_q[p])
            );

            assign mode_code[p] = {cap2_q[p], cap1_q[p][`RRC_BIT_MODE0]};

            always_comb begin
                case (mode_code[p])
                    `RRC_MODE_NORMAL: fcc_mode = rrc_pkg::RRC_FCC_NORMAL;
                    `RRC_MODE_HS1:    fcc_mode = rrc_pkg::RRC_FCC_HS1;
                    `RRC_MODE_HS2:    fcc_mode = rrc_pkg::RRC_FCC_HS2;
                    `RRC_MODE_HS4:    fcc_mode = rrc_pkg::RRC_FCC_HS4;
                    default:          fcc_mode = rrc_pkg::RRC_FCC_OTHER;
                endcase
            end

            always_comb begin
                case (fcc_mode)
                    rrc_pkg::RRC_FCC_HS1: gpio_cnt_next = `RRC_GPIO_ONE;
                    rrc_pkg::RRC_FCC_HS2: gpio_cnt_next = `RRC_GPIO_TWO;
                    rrc_pkg::RRC_FCC_HS4: gpio_cnt_next = `RRC_GPIO_FOUR;
                    default:              gpio_cnt_next = `RRC_GPIO_NONE;
                endcase
            end

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    gpio_cnt_reg[p] <= `RRC_COUNT_RST;
                    mode_rsv_reg[p] <= 1'b0;
                end else begin
                    gpio_cnt_reg[p] <= gpio_cnt_next;
                    mode_rsv_reg[p] <= (fcc_mode == rrc_pkg::RRC_FCC_OTHER);
                end
            end

            assign send_frequency_training[p]    = cap1_q[p][`RRC_BIT_FREQ];
            assign send_equalization_training[p] = cap1_q[p][`RRC_BIT_EQ];
            assign dual_link_capable[p]          = cap1_q[p][`RRC_BIT_DUAL];
            assign channel_index_flag[p]         = cap1_q[p][`RRC_BIT_DUAL] &
                                                   cap1_q[p][`RRC_BIT_CHAN];
        end
    endgenerate

    assign fast_ctrl_gpio_count    = gpio_cnt_reg;
    assign fast_ctrl_mode_reserved = mode_rsv_reg;
    assign dual_link_active        = dual_link_request & cap1_q[0][`RRC_BIT_DUAL] &
                                     cap1_q[1][`RRC_BIT_DUAL];

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire [7:0] rd_cap1 = tgt_p1 ? cap1_q[1] : cap1_q[0];
    wire [1:0] rd_cap2 = tgt_p1 ? cap2_q[1] : cap2_q[0];
    wire [7:0] rd_mux  = addr_psel ? {5'h00, psel_reg} :
                         addr_cap1 ? rd_cap1 :
                         addr_cap2 ? {6'h00, rd_cap2} : 8'h00;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `RRC_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= rd_ok ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_lock_rise0;
        !rx_lock[0] ##1 rx_lock[0] && !cap1_q[0][`RRC_BIT_FREEZE];
    endsequence

    sequence s_load0;
        bcc_valid[0] && rx_lock[0] && !cap1_q[0][`RRC_BIT_FREEZE] && !wr_cap1[0];
    endsequence

    a_freeze_blocks_load: assert property (
        cap1_q[0][`RRC_BIT_FREEZE] && !wr_cap1[0] |=> $stable(cap1_q[0]))
        else $error("frozen port 0 capability changed without a write");

    a_write_is_kept: assert property (
        wr_cap1[1] |=> cap1_q[1] == $past(reg_wdata))
        else $error("written capability value not stored");

    a_mode_decode_hs4: assert property (
        mode_code[0] == `RRC_MODE_HS4 |=> fast_ctrl_gpio_count[0] == `RRC_GPIO_FOUR)
        else $error("mode code 011 did not give four gpios");

    a_auto_load_lock: assert property (
        s_lock_rise0 ##1 s_load0 |=> cap1_q[0][6:0] == $past(bcc_cap1[0]))
        else $error("capability not loaded after receive lock");

    a_freq_request: assert property (
        wr_cap1[0] && reg_wdata[`RRC_BIT_FREQ] |=> send_frequency_training[0] ##1
        (send_frequency_training[0] || $past(wr_cap1[0]) || $past(bcc_valid[0])))
        else $error("frequency training not requested");

    a_eq_request: assert property (
        wr_cap1[1] |=> send_equalization_training[1] == $past(reg_wdata[`RRC_BIT_EQ]))
        else $error("equalization training does not follow bit 4");

    a_channel_dual: assert property (
        !dual_link_capable[0] |-> !channel_index_flag[0] && !dual_link_active)
        else $error("channel flag or dual link without dual capability");

    a_view_routes_write: assert property (
        reg_wr && addr_cap1 && !reg_sec_addr && p1_view && !p1_addr_en |=>
        cap1_q[1] == $past(reg_wdata) && $stable(cap1_q[0][`RRC_BIT_FREEZE]))
        else $error("view select write did not reach port 1");

    a_view_routes_read: assert property (
        reg_rd && addr_cap1 && !reg_sec_addr && p1_view && !p1_addr_en |=>
        reg_rdata == $past(cap1_q[1]))
        else $error("view select read did not return port 1");

    a_unfreeze_keeps: assert property (
        $fell(cap1_q[0][`RRC_BIT_FREEZE]) && !wr_cap1[0] |=> $stable(cap1_q[0]) ##1
        ($stable(cap1_q[0]) || $past(wr_cap1[0]) ||
         ($past(rx_lock[0], 2) && !$past(rx_lock[0], 3))))
        else $error("values changed right after freeze cleared");

endmodule : rrc_top

`default_nettype wire

//--- verif/rrc_deser_model.sv
// Purpose: remote deserializer answering over the control channel
// Assumes: driven off the falling edge, DLY sets the answer delay
// Notes:   idle data lines show the inverse of the last frame
`timescale 1ns/1ps
`default_nettype none

module rrc_deser_model #(
    parameter int DLY = 0
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       lock_req,
    input  wire logic       send_req,
    input  wire logic [8:0] send_data,
    output logic            rx_lock,
    output logic            bcc_valid,
    output logic      [6:0] bcc_cap1,
    output logic      [1:0] bcc_mode_hi
);
    logic       lock_q;
    logic       vld_q;
    logic       pend_q;
    logic [8:0] dat_q;
    int         cnt;

    assign rx_lock     = lock_q & resetn;
    assign bcc_valid   = vld_q & resetn;
    assign bcc_cap1    = resetn ? dat_q[6:0] : 7'h55;
    assign bcc_mode_hi = resetn ? dat_q[8:7] : 2'h2;

    always @(negedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lock_q <= 1'b0;
            vld_q  <= 1'b0;
            pend_q <= 1'b0;
            dat_q  <= 9'h0AA;
            cnt    <= 0;
        end else begin
            lock_q <= lock_req;
            vld_q  <= 1'b0;
            if (vld_q) begin
                dat_q <= ~dat_q;
            end
            if (send_req) begin
                pend_q <= 1'b1;
                cnt    <= DLY;
            end else if (pend_q && lock_q && cnt == 0) begin
                pend_q <= 1'b0;
                vld_q  <= 1'b1;
                dat_q  <= send_data;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : rrc_deser_model

`default_nettype wire

//--- verif/rrc_top_bench.sv
// Purpose: self-checking bench of the capability shadow
// Assumes: one far-side model per port, prompt on port 0, slow on port 1
// Notes:   rows walk mode codes 000 to 100 and 111, hand tests cover load, freeze, routing
`timescale 1ns/1ps
`default_nettype none

module rrc_top_bench;
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic [2:0] g;
        logic       r;
        logic       ch;
    } rrc_row_s;

    logic            sys_clk = 1'b0;
    logic            resetn = 1'b0;
    logic [7:0]      reg_addr = 8'h00;
    logic            reg_sec_addr = 1'b0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [7:0]      reg_wdata = 8'h00;
    logic            dual_link_request = 1'b0;
    logic [1:0]      lock_req = 2'h0;
    logic [1:0]      send_req = 2'h0;
    logic [1:0][8:0] send_data = '0;
    logic [7:0]      q;
    int              fail_count = 0;
    int              n_tests = 0;
    int              cycles = 0;
    wire logic [7:0]      reg_rdata;
    wire logic [1:0]      rx_lock, bcc_valid, send_frequency_training;
    wire logic [1:0]      send_equalization_training, dual_link_capable;
    wire logic [1:0]      channel_index_flag, fast_ctrl_mode_reserved;
    wire logic [1:0][6:0] bcc_cap1;
    wire logic [1:0][1:0] bcc_mode_hi;
    wire logic [1:0][2:0] fast_ctrl_gpio_count;
    wire logic            dual_link_active, second_port_address_enable;
    wire logic            second_port_view_select;
    rrc_row_s        rows [6] = '{
        {8'h80, 8'h00, 3'h0, 1'b0, 1'b0}, {8'hC0, 8'h00, 3'h1, 1'b0, 1'b0},
        {8'hA8, 8'h01, 3'h2, 1'b0, 1'b0}, {8'hD4, 8'h01, 3'h4, 1'b0, 1'b0},
        {8'h8C, 8'h02, 3'h0, 1'b1, 1'b1}, {8'hFC, 8'h03, 3'h0, 1'b1, 1'b1}};

    rrc_top rrc_top_inst (.sys_clk, .resetn, .reg_addr, .reg_sec_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .rx_lock, .bcc_valid, .bcc_cap1, .bcc_mode_hi,
        .dual_link_request, .send_frequency_training, .send_equalization_training,
        .dual_link_capable, .channel_index_flag, .fast_ctrl_gpio_count,
        .fast_ctrl_mode_reserved, .dual_link_active, .second_port_address_enable,
        .second_port_view_select);

    for (genvar p = 0; p < 2; p++) begin : g_far
        rrc_deser_model #(.DLY(p * 3)) rrc_deser_model_inst (.sys_clk, .resetn,
            .lock_req(lock_req[p]), .send_req(send_req[p]), .send_data(send_data[p]),
            .rx_lock(rx_lock[p]), .bcc_valid(bcc_valid[p]), .bcc_cap1(bcc_cap1[p]),
            .bcc_mode_hi(bcc_mode_hi[p]));
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d, input logic sec);
        reg_addr <= a;
        reg_wdata <= d;
        reg_sec_addr <= sec;
        reg_wr <= 1'b1;
        @(negedge sys_clk);
        reg_wr <= 1'b0;
        @(negedge sys_clk);
    endtask : wr

    task rchk(input string nm, input logic [7:0] a, input logic sec, input logic [7:0] e);
        reg_addr <= a;
        reg_sec_addr <= sec;
        reg_rd <= 1'b1;
        @(negedge sys_clk);
        reg_rd <= 1'b0;
        q = reg_rdata;
        chk(nm, q, e);
        @(negedge sys_clk);
    endtask : rchk

    task outs(input int p, input logic [7:0] c, input logic [2:0] g, input logic r,
              input logic ch);
        chk("freq", {7'h00, send_frequency_training[p]}, {7'h00, c[5]});
        chk("eq", {7'h00, send_equalization_training[p]}, {7'h00, c[4]});
        chk("dual", {7'h00, dual_link_capable[p]}, {7'h00, c[3]});
        chk("chan", {7'h00, channel_index_flag[p]}, {7'h00, ch});
        chk("gpio", {5'h00, fast_ctrl_gpio_count[p]}, {5'h00, g});
        chk("rsvd", {7'h00, fast_ctrl_mode_reserved[p]}, {7'h00, r});
    endtask : outs

    task link(input int p, input logic [8:0] d, input logic relock);
        if (relock) begin
            lock_req[p] <= 1'b0;
            repeat (3) @(negedge sys_clk);
        end
        lock_req[p] <= 1'b1;
        send_req[p] <= 1'b1;
        send_data[p] <= d;
        @(negedge sys_clk);
        send_req[p] <= 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask : link

    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // clock, timeout and sequence
    // ------------------------------------------------------------
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            $display("[ERR] timeout expected done seen hang");
            end_sim();
        end
    end

    initial begin
        repeat (10) @(negedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        rchk("cap1_rst", 8'h20, 1'b0, 8'h00);
        rchk("cap2_rst", 8'h21, 1'b0, 8'h00);
        rchk("psel_rst", 8'h1E, 1'b0, 8'h04);
        outs(0, 8'h00, 3'h0, 1'b0, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(8'h20, rows[i].c1, 1'b0);
            wr(8'h21, rows[i].c2, 1'b0);
            rchk("cap1", 8'h20, 1'b0, rows[i].c1);
            rchk("cap2", 8'h21, 1'b0, rows[i].c2);
            outs(0, rows[i].c1, rows[i].g, rows[i].r, rows[i].ch);
        end
        $display("test rows done");
        wr(8'h20, 8'h00, 1'b0);
        wr(8'h21, 8'h00, 1'b0);
        link(0, 9'h0AA, 1'b1);
        link(1, 9'h155, 1'b1);
        rchk("load1", 8'h20, 1'b0, 8'h2A);
        rchk("load2", 8'h21, 1'b0, 8'h01);
        outs(0, 8'h2A, 3'h2, 1'b0, 1'b0);
        outs(1, 8'h55, 3'h0, 1'b1, 1'b0);
        $display("test load done");
        wr(8'h20, 8'h91, 1'b0);
        wr(8'h21, 8'h02, 1'b0);
        link(0, 9'h1FF, 1'b1);
        rchk("frz1", 8'h20, 1'b0, 8'h91);
        rchk("frz2", 8'h21, 1'b0, 8'h02);
        outs(0, 8'h91, 3'h0, 1'b1, 1'b0);
        wr(8'h20, 8'h11, 1'b0);
        link(0, 9'h1FF, 1'b0);
        rchk("thaw", 8'h20, 1'b0, 8'h11);
        link(0, 9'h105, 1'b1);
        rchk("relock", 8'h20, 1'b0, 8'h05);
        $display("test freeze done");
        wr(8'h1E, 8'h02, 1'b0);
        wr(8'h20, 8'hA8, 1'b0);
        rchk("view", 8'h20, 1'b0, 8'hA8);
        chk("freq2", {6'h00, send_frequency_training}, 8'h02);
        chk("psel", {6'h00, second_port_address_enable, second_port_view_select}, 8'h01);
        rchk("sec_off", 8'h20, 1'b1, 8'h00);
        wr(8'h20, 8'hFF, 1'b1);
        wr(8'h1E, 8'h04, 1'b0);
        rchk("sec_on", 8'h20, 1'b1, 8'hA8);
        rchk("prim", 8'h20, 1'b0, 8'h05);
        rchk("unmap", 8'h22, 1'b0, 8'h00);
        $display("test routing done");
        dual_link_request <= 1'b1;
        wr(8'h20, 8'h8C, 1'b0);
        chk("dla_on", {7'h00, dual_link_active}, 8'h01);
        chk("chan2", {6'h00, channel_index_flag}, 8'h01);
        dual_link_request <= 1'b0;
        @(negedge sys_clk);
        chk("dla_off", {7'h00, dual_link_active}, 8'h00);
        $display("test dual done");
        resetn <= 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        rchk("cap1_rst2", 8'h20, 1'b0, 8'h00);
        rchk("psel_rst2", 8'h1E, 1'b0, 8'h04);
        outs(0, 8'h00, 3'h0, 1'b0, 1'b0);
        $display("test mid reset done");
        end_sim();
    end
endmodule : rrc_top_bench

`default_nettype wire
